// >>> rx_queue_status_flags.sv
// holds the three receive-queue status flags of the link interrupt register
// assumes host reads and writes are one-cycle strobes synchronous to clk
`timescale 1ns/10ps
`include "rx_flags_cfg.svh"
module rx_queue_status_flags (
    input wire logic clk,
    input wire logic rst,
    input wire logic resp_head_valid,
    input wire logic resp_head_last,
    input wire logic req_head_valid,
    input wire logic req_head_last,
    input wire logic resp_read_req,
    input wire logic req_read_req,
    input wire logic resp_xfer_error,
    input wire logic bus_reset,
    input wire logic status_write,
    input wire rx_flags_pkg::status_bits_t status_wdata,
    output logic resp_read_grant,
    output logic req_read_grant,
    output logic resp_queue_last_quadlet_flag,
    output logic req_queue_last_quadlet_flag,
    output logic resp_queue_read_error_flag,
    output rx_flags_pkg::status_bits_t status_rdata
);
    import rx_flags_pkg::*;
    err_flag_if ef ();
    logic resp_last_reg;
    logic resp_last_next;
    logic req_last_reg;
    logic req_last_next;
    status_bits_t rdata_reg;
    status_bits_t rdata_next;

    // ==========================================
    // error flag and read blocking
    assign ef.set_event = resp_xfer_error || bus_reset;
    assign ef.clear_write = status_write && status_wdata[`RESP_RDERR_BIT];
    resp_err_tracker u_err (
        .clk(clk),
        .rst(rst),
        .ef(ef)
    );
    assign resp_read_grant = resp_read_req && resp_head_valid && !ef.flag;
    assign req_read_grant = req_read_req && req_head_valid;

    // ==========================================
    // last-quadlet flags follow the head one cycle late, drop the cycle after the head is read
    always_comb begin
        resp_last_next = resp_head_valid && resp_head_last && !resp_read_grant;
        req_last_next = req_head_valid && req_head_last && !req_read_grant;
        rdata_next = '0;
        rdata_next[`RESP_LASTQ_BIT] = resp_last_next;
        rdata_next[`REQ_LASTQ_BIT] = req_last_next;
        rdata_next[`RESP_RDERR_BIT] = ef.set_event || (ef.flag && !ef.clear_write);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resp_last_reg <= `FLAG_RESET_VAL;
            req_last_reg <= `FLAG_RESET_VAL;
            rdata_reg <= '0;
        end else begin
            resp_last_reg <= resp_last_next;
            req_last_reg <= req_last_next;
            rdata_reg <= rdata_next;
        end
    end

    assign resp_queue_last_quadlet_flag = resp_last_reg;
    assign req_queue_last_quadlet_flag = req_last_reg;
    assign resp_queue_read_error_flag = ef.flag;
    assign status_rdata = rdata_reg;

    // ==========================================
    // assertions
    a_resp_last_track: assert property (@(posedge clk) disable iff (rst)
        (resp_head_valid && resp_head_last && !resp_read_grant)
        |=> resp_queue_last_quadlet_flag) else $error("resp last flag missing");
    a_req_last_track: assert property (@(posedge clk) disable iff (rst)
        (req_head_valid && req_head_last && !req_read_grant)
        |=> req_queue_last_quadlet_flag) else $error("req last flag missing");
    a_resp_read_clears: assert property (@(posedge clk) disable iff (rst)
        resp_read_grant |=> !resp_queue_last_quadlet_flag)
        else $error("resp last flag not cleared by read");
    a_req_read_clears: assert property (@(posedge clk) disable iff (rst)
        req_read_grant |=> !req_queue_last_quadlet_flag)
        else $error("req last flag not cleared by read");
    a_resp_read_block: assert property (@(posedge clk) disable iff (rst)
        resp_queue_read_error_flag |-> !resp_read_grant)
        else $error("read granted while blocked");
    a_err_on_busreset: assert property (@(posedge clk) disable iff (rst)
        bus_reset |=> resp_queue_read_error_flag && status_rdata[`RESP_RDERR_BIT])
        else $error("bus reset did not set error");
    a_zero_write_ignored: assert property (@(posedge clk) disable iff (rst)
        (resp_queue_read_error_flag && status_write && !status_wdata[`RESP_RDERR_BIT])
        |=> resp_queue_read_error_flag) else $error("zero write cleared error");
    a_unblock_after_clear: assert property (@(posedge clk) disable iff (rst)
        (resp_queue_read_error_flag && ef.clear_write && !ef.set_event)
        ##1 (resp_read_req && resp_head_valid) |-> resp_read_grant)
        else $error("queue still blocked after clear");
    c_resp_last_read: cover property (@(posedge clk) disable iff (rst)
        resp_queue_last_quadlet_flag ##1 resp_read_grant);
    c_error_cleared: cover property (@(posedge clk) disable iff (rst)
        resp_queue_read_error_flag ##1 ef.clear_write ##1 !resp_queue_read_error_flag);
    c_blocked_read: cover property (@(posedge clk) disable iff (rst)
        resp_queue_read_error_flag && resp_read_req);
endmodule : rx_queue_status_flags

// >>> rx_flags_cfg.svh
// holds bit positions and reset values of the receive-queue status flags
// assumes inclusion by bare name from the package and the top module
`ifndef RX_FLAGS_CFG_SVH
`define RX_FLAGS_CFG_SVH
`define RESP_LASTQ_BIT 13
`define REQ_LASTQ_BIT 12
`define RESP_RDERR_BIT 11
`define FLAG_RESET_VAL 1'b0
`define SEL_RESP 1'b0
`define SEL_REQ 1'b1
`endif

// >>> rx_flags_pkg.sv
// holds the types shared by the receive-queue flag block
// assumes rx_flags_cfg.svh is on the include path
`include "rx_flags_cfg.svh"
package rx_flags_pkg;
    typedef enum logic [1:0] {
        ERR_CLEAR = 2'b01,
        ERR_BLOCKED = 2'b10
    } err_state_t;
    typedef logic [15:0] status_bits_t;
endpackage : rx_flags_pkg

// >>> err_flag_if.sv
// holds the interface joining the top module to its error flag tracker
// assumes a single clock domain
`timescale 1ns/10ps
interface err_flag_if;
    logic set_event;
    logic clear_write;
    logic flag;
    modport owner (input set_event, input clear_write, output flag);
    modport user (output set_event, output clear_write, input flag);
endinterface : err_flag_if

// >>> resp_err_tracker.sv
// holds the response-queue error flag state machine
// assumes synchronous active-high reset on clk
`timescale 1ns/10ps
module resp_err_tracker (
    input wire logic clk,
    input wire logic rst,
    err_flag_if.owner ef
);
    import rx_flags_pkg::*;
    err_state_t state_reg;
    err_state_t state_next;

    // ==========================================
    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ERR_CLEAR: begin
                if (ef.set_event) begin
                    state_next = ERR_BLOCKED;
                end
            end
            ERR_BLOCKED: begin
                if (ef.clear_write && !ef.set_event) begin
                    state_next = ERR_CLEAR;
                end
            end
            default: state_next = ERR_CLEAR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ERR_CLEAR;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ef.flag = (state_reg == ERR_BLOCKED);

    // ==========================================
    // assertions
    a_err_set_sticky: assert property (@(posedge clk) disable iff (rst)
        ef.set_event |=> ef.flag) else $error("error flag not set");
    a_err_clear_w1c: assert property (@(posedge clk) disable iff (rst)
        (ef.flag && ef.clear_write && !ef.set_event) |=> !ef.flag)
        else $error("error flag not cleared");
    a_err_hold: assert property (@(posedge clk) disable iff (rst)
        (ef.flag && !ef.clear_write) |=> ef.flag) else $error("error flag dropped");
endmodule : resp_err_tracker

// >>> rx_queue_model.sv
// holds a queue-head model for one receive queue of the flag block
// assumes clk/rst of the flag block; pop is that queue's read grant
`timescale 1ns/10ps
module rx_queue_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic pop,
    input wire logic stall,
    input wire logic [2:0] pkt_len,
    output logic head_valid,
    output logic head_last
);
    logic [2:0] left_reg;
    logic [2:0] left_next;
    // ==========
    // quadlets left in the packet at the head
    always_comb begin
        left_next = left_reg;
        if (pop) begin
            left_next = (left_reg == 3'h0) ? pkt_len : left_reg - 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            left_reg <= 3'h2;
        end else begin
            left_reg <= left_next;
        end
    end
    assign head_valid = !stall;
    assign head_last = (left_reg == 3'h0);
endmodule : rx_queue_model

// >>> rx_queue_status_flags_tb_top.sv
// holds the self-checking bench of the receive-queue status flags
// assumes the flag block and rx_queue_model compiled before it
`timescale 1ns/10ps
module rx_queue_status_flags_tb_top;
    import rx_flags_pkg::*;
    logic clk, rst, rv, rl, qv, ql, rr, qr, xe, br, sw, rg, qg, f_rl, f_ql, f_er;
    logic e_rl, e_ql, e_er, e_rg, e_qg;
    status_bits_t wd, rd;
    logic [31:0] r;
    integer seed = 81663, num_errors = 0, samples_checked = 0, i;
    rx_queue_status_flags dut (.clk(clk), .rst(rst), .resp_head_valid(rv),
        .resp_head_last(rl), .req_head_valid(qv), .req_head_last(ql), .resp_read_req(rr),
        .req_read_req(qr), .resp_xfer_error(xe), .bus_reset(br), .status_write(sw),
        .status_wdata(wd), .resp_read_grant(rg), .req_read_grant(qg),
        .resp_queue_last_quadlet_flag(f_rl), .req_queue_last_quadlet_flag(f_ql),
        .resp_queue_read_error_flag(f_er), .status_rdata(rd));
    rx_queue_model resp_q (.clk(clk), .rst(rst), .pop(rg), .stall(r[2]),
        .pkt_len(r[15:13]), .head_valid(rv), .head_last(rl));
    rx_queue_model req_q (.clk(clk), .rst(rst), .pop(qg), .stall(r[3]),
        .pkt_len(r[30:28]), .head_valid(qv), .head_last(ql));
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_word(input status_bits_t got, input status_bits_t exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_word
    task automatic print_verdict;
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // ==========
    // reference flags
    assign e_rg = rr & rv & !e_er;
    assign e_qg = qr & qv;
    always @(posedge clk) begin
        if (rst) begin
            {e_rl, e_ql, e_er} <= 3'b000;
        end else begin
            e_rl <= rv & rl & !e_rg;
            e_ql <= qv & ql & !e_qg;
            e_er <= xe | br | (e_er & !(sw & wd[11]));
        end
    end
    always @(negedge clk) begin
        if (!rst) begin
            check_bit(rg, e_rg);
            check_bit(qg, e_qg);
            check_bit(f_rl, e_rl);
            check_bit(f_ql, e_ql);
            check_bit(f_er, e_er);
            check_word(rd, {2'b00, e_rl, e_ql, e_er, 11'h000});
        end
    end
    // ==========
    // clock, reset, stimulus
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
    initial begin
        {rst, rr, qr, xe, br, sw, r} = {1'b1, 5'h00, 1'b0, 32'h0};
        wd = 16'h0000;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1 r = $random(seed);
            {rr, qr} = (i > 5 && i < 12) ? 2'b11 : r[1:0];
            xe = (i < 12) ? 1'b0 : (r[7:4] == 4'h0);
            br = (i == 5) || (r[11:8] == 4'h0 && i > 12);
            sw = (i == 8 || i == 10) ? 1'b1 : (i < 12) ? 1'b0 : r[12];
            wd = (i == 8) ? 16'h0000 : (i == 10) ? 16'h0800 : r[31:16];
        end
        print_verdict();
    end
endmodule : rx_queue_status_flags_tb_top
